// >>> design/xpe_top.sv
// configuration registers: peripheral enables, bus irq control, source select
// assumes a one-cycle register port and inputs synchronous to i_clk_sys
//
// Summary of operation
// - select code 00 pin, 01 alternate, 10 pin OR alt, 11 pin AND alt.
// - channels four to seven have a constant zero alternate source.
// - two-bit group level orders equal-priority requests, 3 highest.
// - four-bit priority level, Fh highest, 0h lowest.
// - enable bit lets the request join arbitration only when set.
// - request flag reads 1 while a request pends; software may write it.
// - irq control layout: request 7, enable 6, level 5..2, group 1..0.
// - first CAN off: hidden, pins free, EF00 window external if both off.
// - second CAN off: hidden, pins free, EE00 window external if both off.
// - small RAM enable routes E000..E7FF internal, else external.
// - large RAM enable routes C000..DFFF internal, else external.
// - RTC off: EC00 window external only if both CAN also off.
// - both CAN off sends EE00..EFFF to the external bus.
// - peripheral enable resets to 05.
// - peripheral enable is frozen once global enable has been set.
// - emulation mode forces every peripheral enable bit set.
// - power-down stops the RTC oscillator unless RTC enabled and not off.
//
// The implementer's own choice: strobed register access.
module xpe_top
    import xpe_pkg::*;
(
    input  wire logic            i_clk_sys,
    input  wire logic            i_nrst,
    input  wire logic [15:0]     i_addr,
    input  wire logic [15:0]     i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [15:0]     o_rdata,
    input  wire logic            i_global_periph_enable,
    input  wire logic            i_emulation,
    input  wire logic            i_power_down,
    input  wire logic            i_rtc_osc_off,
    input  wire logic [7:0]      i_ext_irq_input,
    input  wire logic            i_first_can_receive,
    input  wire logic            i_second_can_receive,
    input  wire logic            i_alt_src2,
    input  wire logic            i_rtc_alarm_irq,
    input  wire logic            i_bus_periph_event,
    input  wire logic [23:0]     i_acc_addr,
    output logic      [7:0]      o_ext_irq,
    output xpe_pkg::xpe_enable_s o_enable,
    output xpe_pkg::xpe_route_s  o_route,
    output logic                 o_first_can_pins_gpio,
    output logic                 o_second_can_pins_gpio,
    output logic                 o_rtc_osc_run,
    output logic                 o_bus_periph_irq_req,
    output logic      [3:0]      o_bus_periph_irq_level,
    output logic      [1:0]      o_group_level
);
    import xpe_pkg::*;

    // ***********************************************************
    // registers
    // ***********************************************************
    logic [4:0]  bus_peripheral_enable;
    logic [7:0]  bus_peripheral_irq_control;
    logic [15:0] ext_irq_source_select;
    logic        locked;
    logic [4:0]  eff_enable;
    logic [7:0]  alt_src;

    function automatic logic in_win(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction : in_win

    // global enable is sticky: once seen, the enable word stays frozen
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            locked <= 1'b0;
        end else if (i_global_periph_enable) begin
            locked <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_peripheral_enable <= XPE_RST_PERIPH_EN;
        end else if (i_wr && i_addr == XPE_OFS_PERIPH_EN
                     && !locked && !i_global_periph_enable) begin
            bus_peripheral_enable <= i_wdata[4:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_irq_source_select <= XPE_RST_SRC_SEL;
        end else if (i_wr && i_addr == XPE_OFS_SRC_SEL) begin
            ext_irq_source_select <= i_wdata;
        end
    end

    // hardware set wins over a software write of zero in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_peripheral_irq_control <= XPE_RST_IRQ_CTRL;
        end else begin
            if (i_wr && i_addr == XPE_OFS_IRQ_CTRL) begin
                bus_peripheral_irq_control <= i_wdata[7:0];
            end
            if (i_bus_periph_event) begin
                bus_peripheral_irq_control[XPE_BIT_IRQ_REQ] <= 1'b1;
            end
        end
    end

    // ***********************************************************
    // read port
    // ***********************************************************
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            case (i_addr)
                XPE_OFS_PERIPH_EN: o_rdata <= {11'h000, eff_enable};
                XPE_OFS_IRQ_CTRL:
                    o_rdata <= {8'h00, bus_peripheral_irq_control};
                XPE_OFS_SRC_SEL:   o_rdata <= ext_irq_source_select;
                default:           o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // ***********************************************************
    // enables and routing
    // ***********************************************************
    assign eff_enable = i_emulation ? 5'h1F : bus_peripheral_enable;
    assign o_enable   = xpe_enable_s'(eff_enable);

    assign o_first_can_pins_gpio  = !eff_enable[XPE_BIT_CAN1];
    assign o_second_can_pins_gpio = !eff_enable[XPE_BIT_CAN2];

    // rtc oscillator only survives power-down when enabled and not off
    assign o_rtc_osc_run = !i_power_down
        || (eff_enable[XPE_BIT_RTC] && !i_rtc_osc_off);

    logic both_can_off;
    assign both_can_off = !eff_enable[XPE_BIT_CAN1]
                          && !eff_enable[XPE_BIT_CAN2];

    always_comb begin
        o_route = '0;
        if (in_win(i_acc_addr, XPE_WIN_RAML_LO, XPE_WIN_RAML_HI)) begin
            o_route.large_ram = eff_enable[XPE_BIT_RAML];
            o_route.external  = !eff_enable[XPE_BIT_RAML];
        end else if (in_win(i_acc_addr, XPE_WIN_RAMS_LO,
                            XPE_WIN_RAMS_HI)) begin
            o_route.small_ram = eff_enable[XPE_BIT_RAMS];
            o_route.external  = !eff_enable[XPE_BIT_RAMS];
        end else if (in_win(i_acc_addr, XPE_WIN_RTC_LO,
                            XPE_WIN_RTC_HI)) begin
            o_route.rtc      = eff_enable[XPE_BIT_RTC];
            o_route.external = !eff_enable[XPE_BIT_RTC] && both_can_off;
        end else if (in_win(i_acc_addr, XPE_WIN_CAN2_LO,
                            XPE_WIN_CAN2_HI)) begin
            o_route.second_can = eff_enable[XPE_BIT_CAN2];
            o_route.external   = both_can_off;
        end else if (in_win(i_acc_addr, XPE_WIN_CAN1_LO,
                            XPE_WIN_CAN1_HI)) begin
            o_route.first_can = eff_enable[XPE_BIT_CAN1];
            o_route.external  = both_can_off;
        end
    end

    // ***********************************************************
    // interrupt request to the arbiter
    // ***********************************************************
    assign o_bus_periph_irq_req =
        bus_peripheral_irq_control[XPE_BIT_IRQ_REQ]
        && bus_peripheral_irq_control[XPE_BIT_IRQ_EN];
    assign o_bus_periph_irq_level =
        bus_peripheral_irq_control[XPE_POS_LEVEL +: 4];
    assign o_group_level =
        bus_peripheral_irq_control[XPE_POS_GROUP +: 2];

    assign alt_src = {4'h0, i_rtc_alarm_irq, i_alt_src2,
                      i_second_can_receive, i_first_can_receive};

    xpe_irq_select #(
        .CHANNELS (XPE_NUM_CHAN)
    ) xpe_irq_select_inst (
        .i_select (ext_irq_source_select),
        .i_pin    (i_ext_irq_input),
        .i_alt    (alt_src),
        .o_irq    (o_ext_irq)
    );

    // ***********************************************************
    // assertions
    // ***********************************************************
    property p_lock;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        locked |=> $stable(bus_peripheral_enable);
    endproperty
    a_lock: assert property (p_lock)
        else $error("enable changed after lock");

    property p_wr_lock;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_wr && i_addr == XPE_OFS_PERIPH_EN
            && (locked || i_global_periph_enable))
            |=> $stable(bus_peripheral_enable);
    endproperty
    a_wr_lock: assert property (p_wr_lock)
        else $error("locked write took effect");

    property p_wr_en;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_wr && i_addr == XPE_OFS_PERIPH_EN
            && !locked && !i_global_periph_enable)
            |=> {11'h000, bus_peripheral_enable}
                == ($past(i_wdata) & 16'h001F);
    endproperty
    a_wr_en: assert property (p_wr_en)
        else $error("enable write lost");

    property p_emu;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_emulation |-> o_enable == xpe_enable_s'(5'h1F);
    endproperty
    a_emu: assert property (p_emu)
        else $error("emulation not all set");

    property p_req_set;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_bus_periph_event |=> bus_peripheral_irq_control[XPE_BIT_IRQ_REQ];
    endproperty
    a_req_set: assert property (p_req_set)
        else $error("request lost");

    // a clearing write must stick when no event collides with it
    property p_req_clr;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_wr && i_addr == XPE_OFS_IRQ_CTRL && !i_wdata[XPE_BIT_IRQ_REQ]
            && !i_bus_periph_event)
            |=> !bus_peripheral_irq_control[XPE_BIT_IRQ_REQ];
    endproperty
    a_req_clr: assert property (p_req_clr)
        else $error("request flag not cleared");

    // an enabled source reaches the arbiter the cycle after its event
    property p_gate;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_bus_periph_event && bus_peripheral_irq_control[XPE_BIT_IRQ_EN]
            && !(i_wr && i_addr == XPE_OFS_IRQ_CTRL))
            |=> o_bus_periph_irq_req;
    endproperty
    a_gate: assert property (p_gate)
        else $error("enabled request not raised");

    property p_mask;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !bus_peripheral_irq_control[XPE_BIT_IRQ_EN] |-> !o_bus_periph_irq_req;
    endproperty
    a_mask: assert property (p_mask)
        else $error("disabled request out");

    property p_can_ext;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_acc_addr[23:9] == 15'h0077 && !both_can_off)
            |-> !o_route.external;
    endproperty
    a_can_ext: assert property (p_can_ext)
        else $error("CAN window external");

    property p_rd;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_rd && i_addr == XPE_OFS_PERIPH_EN)
            |=> o_rdata == {11'h000, $past(eff_enable)};
    endproperty
    a_rd: assert property (p_rd)
        else $error("enable read wrong");

    // read data stand for one cycle only, so stale words never linger
    property p_rd_idle;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_rd |=> o_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");

    property p_hi_alt;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        ext_irq_source_select[15:14] == XPE_SS_ALT |-> !o_ext_irq[7];
    endproperty
    a_hi_alt: assert property (p_hi_alt)
        else $error("alt on ch7");

    property p_or_hi;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        ext_irq_source_select[9:8] == XPE_SS_OR
            |-> o_ext_irq[4] == i_ext_irq_input[4];
    endproperty
    a_or_hi: assert property (p_or_hi)
        else $error("alt leaked into ch4");

    property p_pin0;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        ext_irq_source_select[1:0] == XPE_SS_AND
            |-> o_ext_irq[0] == (i_ext_irq_input[0] & i_first_can_receive);
    endproperty
    a_pin0: assert property (p_pin0)
        else $error("and select wrong on ch0");

    property p_raml;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        in_win(i_acc_addr, XPE_WIN_RAML_LO, XPE_WIN_RAML_HI)
            |-> (o_route.large_ram == o_enable.large_ram)
                && (o_route.external != o_enable.large_ram);
    endproperty
    a_raml: assert property (p_raml)
        else $error("large ram window misrouted");

    property p_rams;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        in_win(i_acc_addr, XPE_WIN_RAMS_LO, XPE_WIN_RAMS_HI)
            |-> (o_route.small_ram == o_enable.small_ram)
                && (o_route.external != o_enable.small_ram);
    endproperty
    a_rams: assert property (p_rams)
        else $error("small ram window misrouted");

    property p_rtc;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (in_win(i_acc_addr, XPE_WIN_RTC_LO, XPE_WIN_RTC_HI) && o_enable.rtc)
            |-> o_route.rtc && !o_route.external;
    endproperty
    a_rtc: assert property (p_rtc)
        else $error("rtc window misrouted");

    property p_osc;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_power_down && !eff_enable[XPE_BIT_RTC]) |-> !o_rtc_osc_run;
    endproperty
    a_osc: assert property (p_osc)
        else $error("osc ran in power-down");

    property p_awake;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_power_down |-> o_rtc_osc_run;
    endproperty
    a_awake: assert property (p_awake)
        else $error("osc stopped while awake");

    c_lock: cover property (@(posedge i_clk_sys) locked && i_wr
                            && i_addr == XPE_OFS_PERIPH_EN);
    c_ext:  cover property (@(posedge i_clk_sys) o_route.external);
    c_req:  cover property (@(posedge i_clk_sys) o_bus_periph_irq_req);
    c_collide: cover property (@(posedge i_clk_sys) i_bus_periph_event
                               && i_wr && i_addr == XPE_OFS_IRQ_CTRL);
    c_emu:  cover property (@(posedge i_clk_sys) i_emulation);
endmodule : xpe_top

// >>> design/xpe_pkg.sv
// package for the bus peripheral enable and external interrupt select block
// assumes a 16-bit register port with 16-bit addresses
package xpe_pkg;
    // ***********************************************************
    // register offsets
    // ***********************************************************
    localparam logic [15:0] XPE_OFS_PERIPH_EN  = 16'hF024;
    localparam logic [15:0] XPE_OFS_IRQ_CTRL   = 16'hF19E;
    localparam logic [15:0] XPE_OFS_SRC_SEL    = 16'hF1DA;
    // ***********************************************************
    // reset values
    // ***********************************************************
    localparam logic [4:0]  XPE_RST_PERIPH_EN  = 5'h05;
    localparam logic [15:0] XPE_RST_SRC_SEL    = 16'h0000;
    localparam logic [7:0]  XPE_RST_IRQ_CTRL   = 8'h00;
    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int XPE_BIT_CAN1 = 0;
    localparam int XPE_BIT_CAN2 = 1;
    localparam int XPE_BIT_RAMS = 2;
    localparam int XPE_BIT_RAML = 3;
    localparam int XPE_BIT_RTC  = 4;
    localparam int XPE_BIT_IRQ_REQ = 7;
    localparam int XPE_BIT_IRQ_EN  = 6;
    localparam int XPE_POS_LEVEL   = 2;
    localparam int XPE_POS_GROUP   = 0;
    localparam int XPE_NUM_CHAN    = 8;
    localparam int XPE_NUM_ALT     = 4;
    // ***********************************************************
    // source select codes and address windows
    // ***********************************************************
    localparam logic [1:0] XPE_SS_PIN = 2'h0;
    localparam logic [1:0] XPE_SS_ALT = 2'h1;
    localparam logic [1:0] XPE_SS_OR  = 2'h2;
    localparam logic [1:0] XPE_SS_AND = 2'h3;
    localparam logic [23:0] XPE_WIN_RAML_LO = 24'h00C000;
    localparam logic [23:0] XPE_WIN_RAML_HI = 24'h00DFFF;
    localparam logic [23:0] XPE_WIN_RAMS_LO = 24'h00E000;
    localparam logic [23:0] XPE_WIN_RAMS_HI = 24'h00E7FF;
    localparam logic [23:0] XPE_WIN_RTC_LO  = 24'h00EC00;
    localparam logic [23:0] XPE_WIN_RTC_HI  = 24'h00ECFF;
    localparam logic [23:0] XPE_WIN_CAN2_LO = 24'h00EE00;
    localparam logic [23:0] XPE_WIN_CAN2_HI = 24'h00EEFF;
    localparam logic [23:0] XPE_WIN_CAN1_LO = 24'h00EF00;
    localparam logic [23:0] XPE_WIN_CAN1_HI = 24'h00EFFF;

    typedef struct packed {
        logic rtc;
        logic large_ram;
        logic small_ram;
        logic second_can;
        logic first_can;
    } xpe_enable_s;

    typedef struct packed {
        logic large_ram;
        logic small_ram;
        logic rtc;
        logic second_can;
        logic first_can;
        logic external;
    } xpe_route_s;
endpackage : xpe_pkg

// >>> design/xpe_irq_select.sv
// source selection for the eight external interrupt channels
// assumes pin and alternate inputs are synchronous to the clock
module xpe_irq_select
    import xpe_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input  wire logic [2*CHANNELS-1:0] i_select,
    input  wire logic [CHANNELS-1:0]   i_pin,
    input  wire logic [CHANNELS-1:0]   i_alt,
    output logic      [CHANNELS-1:0]   o_irq
);
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            case (i_select[2*c +: 2])
                XPE_SS_PIN: o_irq[c] = i_pin[c];
                XPE_SS_ALT: o_irq[c] = i_alt[c];
                XPE_SS_OR:  o_irq[c] = i_pin[c] | i_alt[c];
                XPE_SS_AND: o_irq[c] = i_pin[c] & i_alt[c];
                default:    o_irq[c] = i_pin[c];
            endcase
        end
    end
endmodule : xpe_irq_select

// >>> tb/tb_top.sv
// self-checking bench for the peripheral enable and irq select block
// assumes one-cycle register port, read data the cycle after the strobe
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import xpe_pkg::*;

    // ***********************************************************
    // signals and design
    // ***********************************************************
    logic        clk, nrst, wr, rd, gpe, emu, pd, oscoff, ev;
    logic        can1rx, can2rx, alt2, rtc_alarm_irq, g1, g2, osc, ireq;
    logic [15:0] addr, wdata, rdata;
    logic [7:0]  pins, eirq;
    logic [23:0] acc;
    logic [3:0]  lvl;
    logic [1:0]  grp;
    xpe_enable_s en;
    xpe_route_s  route;
    int          n_fail, total_checks;
    logic [23:0] wins [5] = '{24'h00C000, 24'h00E7FF, 24'h00ECFF,
                              24'h00EE00, 24'h00EFFF};
    logic [15:0] sels [6] = '{16'h0000, 16'h5555, 16'hAAAA, 16'hFFFF,
                              16'hE4E4, 16'h1B1B};

    xpe_top xpe_top_inst (
        .i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_global_periph_enable(gpe), .i_emulation(emu),
        .i_power_down(pd), .i_rtc_osc_off(oscoff),
        .i_ext_irq_input(pins), .i_first_can_receive(can1rx),
        .i_second_can_receive(can2rx), .i_alt_src2(alt2),
        .i_rtc_alarm_irq(rtc_alarm_irq), .i_bus_periph_event(ev),
        .i_acc_addr(acc), .o_ext_irq(eirq), .o_enable(en),
        .o_route(route), .o_first_can_pins_gpio(g1),
        .o_second_can_pins_gpio(g2), .o_rtc_osc_run(osc),
        .o_bus_periph_irq_req(ireq), .o_bus_periph_irq_level(lvl),
        .o_group_level(grp)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ***********************************************************
    // tasks and models
    // ***********************************************************
    task automatic end_sim;
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic pulse_event;
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        #1;
    endtask : pulse_event

    function automatic logic [7:0] exp_irq(input logic [15:0] s,
                                           input logic [7:0] p,
                                           input logic [3:0] a);
        logic [7:0] r;
        logic [7:0] al;
        al = {4'h0, a};
        for (int c = 0; c < 8; c++) begin
            case (s[2*c +: 2])
                2'h0:    r[c] = p[c];
                2'h1:    r[c] = al[c];
                2'h2:    r[c] = p[c] | al[c];
                default: r[c] = p[c] & al[c];
            endcase
        end
        return r;
    endfunction : exp_irq

    // window order: large ram, small ram, rtc, can2, can1
    function automatic logic [5:0] exp_route(input logic [4:0] e,
                                             input int w);
        case (w)
            0: return e[3] ? 6'h20 : 6'h01;
            1: return e[2] ? 6'h10 : 6'h01;
            2: return e[4] ? 6'h08 : ((e[1:0] == 2'h0) ? 6'h01 : 6'h00);
            3: return e[1] ? 6'h04 : (!e[0] ? 6'h01 : 6'h00);
            default: return e[0] ? 6'h02 : (!e[1] ? 6'h01 : 6'h00);
        endcase
    endfunction : exp_route

    // ***********************************************************
    // sequence
    // ***********************************************************
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("mismatch at %0t: run too long", $time);
        end_sim();
    end

    initial begin
        logic [4:0] e;
        {wr, rd, gpe, emu, pd, oscoff, ev} = '0;
        {can1rx, can2rx, alt2, rtc_alarm_irq} = '0;
        {addr, wdata, pins, acc} = '0;
        nrst = 1'b0;
        n_fail = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(XPE_OFS_PERIPH_EN, 16'h0005);
        rd_chk(XPE_OFS_SRC_SEL, 16'h0000);
        rd_chk(XPE_OFS_IRQ_CTRL, 16'h0000);
        chk({11'h0, en}, 16'h0005);
        for (int i = 0; i < 6; i++) begin
            wr_reg(XPE_OFS_SRC_SEL, sels[i]);
            rd_chk(XPE_OFS_SRC_SEL, sels[i]);
            for (int k = 0; k < 2; k++) begin
                @(posedge clk);
                pins <= k ? 8'h5C : 8'hA3;
                {rtc_alarm_irq, alt2, can2rx, can1rx} <= k ? 4'hA : 4'h5;
                #1;
                chk({8'h0, eirq}, {8'h0, exp_irq(sels[i], pins,
                    {rtc_alarm_irq, alt2, can2rx, can1rx})});
            end
        end
        // every enable combination against one edge of each window
        @(posedge clk);
        pd <= 1'b1;
        for (int v = 0; v < 32; v++) begin
            e = v[4:0];
            wr_reg(XPE_OFS_PERIPH_EN, {11'h0, e});
            rd_chk(XPE_OFS_PERIPH_EN, {11'h0, e});
            @(posedge clk);
            oscoff <= e[2];
            #1;
            chk({11'h0, en}, {11'h0, e});
            chk({15'h0, g1}, {15'h0, !e[0]});
            chk({15'h0, g2}, {15'h0, !e[1]});
            chk({15'h0, osc}, {15'h0, e[4] & !e[2]});
            for (int w = 0; w < 5; w++) begin
                @(posedge clk);
                acc <= wins[w];
                #1;
                chk({10'h0, route},
                    {10'h0, exp_route(e, w)});
            end
        end
        @(posedge clk);
        pd <= 1'b0;
        #1;
        chk({15'h0, osc}, 16'h0001);
        // irq control: layout, enable gating, request flag
        wr_reg(XPE_OFS_IRQ_CTRL, 16'h007F);
        chk({10'h0, lvl, grp}, 16'h003F);
        chk({15'h0, ireq}, 16'h0000);
        pulse_event();
        chk({15'h0, ireq}, 16'h0001);
        rd_chk(XPE_OFS_IRQ_CTRL, 16'h00FF);
        wr_reg(XPE_OFS_IRQ_CTRL, 16'h00B6);
        chk({10'h0, lvl, grp}, 16'h0036);
        chk({15'h0, ireq}, 16'h0000);
        rd_chk(XPE_OFS_IRQ_CTRL, 16'h00B6);
        wr_reg(XPE_OFS_IRQ_CTRL, 16'h0040);
        chk({15'h0, ireq}, 16'h0000);
        pulse_event();
        chk({15'h0, ireq}, 16'h0001);
        // software clear and hardware set in one cycle: the set must win
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= XPE_OFS_IRQ_CTRL;
        wdata <= 16'h0040;
        ev    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        ev <= 1'b0;
        #1;
        chk({15'h0, ireq}, 16'h0001);
        rd_chk(XPE_OFS_IRQ_CTRL, 16'h00C0);
        // emulation overrides the stored enables
        wr_reg(XPE_OFS_PERIPH_EN, 16'h0000);
        @(posedge clk);
        emu <= 1'b1;
        acc <= 24'h00EF00;
        #1;
        chk({11'h0, en}, 16'h001F);
        chk({10'h0, route}, 16'h0002);
        chk({14'h0, g1, g2}, 16'h0000);
        rd_chk(XPE_OFS_PERIPH_EN, 16'h001F);
        @(posedge clk);
        emu <= 1'b0;
        wr_reg(16'hF026, 16'hFFFF);
        rd_chk(16'hF026, 16'h0000);
        rd_chk(XPE_OFS_PERIPH_EN, 16'h0000);
        // lock stays after the global enable drops again
        @(posedge clk);
        gpe   <= 1'b1;
        wr    <= 1'b1;
        addr  <= XPE_OFS_PERIPH_EN;
        wdata <= 16'h001F;
        @(posedge clk);
        gpe <= 1'b0;
        wr  <= 1'b0;
        rd_chk(XPE_OFS_PERIPH_EN, 16'h0000);
        wr_reg(XPE_OFS_PERIPH_EN, 16'h001F);
        rd_chk(XPE_OFS_PERIPH_EN, 16'h0000);
        chk({11'h0, en}, 16'h0000);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(XPE_OFS_PERIPH_EN, 16'h0005);
        wr_reg(XPE_OFS_PERIPH_EN, 16'h001A);
        rd_chk(XPE_OFS_PERIPH_EN, 16'h001A);
        end_sim();
    end
endmodule : tb_top
